// ==== iep_pkg.sv ====
// Package of constants and carrier types for the interrupt enable and priority bank.
package iep_pkg;

  // ************************************************************
  // Bus geometry and answers.
  // ************************************************************
  localparam int unsigned ADDR_W    = 10;     // Byte address width; byte address is four times the index.
  localparam int unsigned DATA_W    = 32;     // Data width of the register bus.
  localparam logic [1:0]  RESP_OKAY = 2'h0;   // Normal answer.
  localparam logic [1:0]  RESP_SLV  = 2'h2;   // Answer to an unmapped address.

  // ************************************************************
  // Register indices (byte address is index times four).
  // ************************************************************
  localparam logic [7:0] IDX_EN_BASIC = 8'ha8;  // Basic enable register.
  localparam logic [7:0] IDX_PH_BASIC = 8'hb7;  // Basic high priority register.
  localparam logic [7:0] IDX_PL_BASIC = 8'hb8;  // Basic low priority register.
  localparam logic [7:0] IDX_EN_EXT   = 8'he8;  // Extended enable register.
  localparam logic [7:0] IDX_PH_EXT   = 8'hf7;  // Extended high priority register.
  localparam logic [7:0] IDX_PL_EXT   = 8'hff;  // Extended low priority register.
  localparam logic [7:0] IDX_STATUS   = 8'h80;  // Read-only status of the controller.

  // ************************************************************
  // Reset values and writable masks.
  // ************************************************************
  localparam logic [7:0] REG_RESET   = 8'h00;   // Every register clears to zero.
  localparam logic [7:0] EN_EXT_MASK = 8'hf7;   // Bit 3 of extended enable is reserved.
  localparam logic [7:0] PR_EXT_MASK = 8'hf3;   // Bits 3:2 of extended priority are reserved.

  // ************************************************************
  // Field positions in the basic registers.
  // ************************************************************
  localparam int unsigned B_GLOBAL = 7;  // Global gate in the enable register.
  localparam int unsigned B_CAPT   = 7;  // Capture priority in the basic priority registers.
  localparam int unsigned B_ADC    = 6;
  localparam int unsigned B_BOD    = 5;
  localparam int unsigned B_UART   = 4;
  localparam int unsigned B_T1     = 3;
  localparam int unsigned B_X1     = 2;
  localparam int unsigned B_T0     = 1;
  localparam int unsigned B_X0     = 0;

  // ************************************************************
  // Field positions in the extended registers.
  // ************************************************************
  localparam int unsigned E_T2   = 7;
  localparam int unsigned E_SPI  = 6;
  localparam int unsigned E_BRK  = 5;
  localparam int unsigned E_WDT  = 4;
  localparam int unsigned E_CAPT = 2;
  localparam int unsigned E_KEY  = 1;
  localparam int unsigned E_I2C  = 0;

  // ************************************************************
  // Polling rank of each source, zero polled first.
  // ************************************************************
  localparam int unsigned N_SRC = 14;
  localparam logic [3:0] R_X0 = 4'h0, R_BOD = 4'h1, R_WDT = 4'h2, R_T0 = 4'h3, R_I2C = 4'h4;
  localparam logic [3:0] R_ADC = 4'h5, R_X1 = 4'h6, R_KEY = 4'h7, R_T1 = 4'h8, R_UART = 4'h9;
  localparam logic [3:0] R_BRK = 4'ha, R_SPI = 4'hb, R_T2 = 4'hc, R_CAPT = 4'hd;

  // Request flags from the peripherals, all on the core clock.
  typedef struct packed {
    logic capture;
    logic timer2;
    logic spi;
    logic brake;
    logic uart_rx_done_flag;
    logic uart_tx_done_flag;
    logic timer1_overflow_flag;
    logic keypad;
    logic adc;
    logic i2c;
    logic timer0_overflow_flag;
    logic watchdog;
    logic brownout;
  } iep_src_t;

  // Request offered to the core's vectoring logic.
  typedef struct packed {
    logic       req;    // A source may be vectored now.
    logic [3:0] id;     // Polling rank of the chosen source.
    logic [1:0] level;  // Priority level of the chosen source.
  } iep_out_t;

endpackage : iep_pkg

// ==== iep_ctrl.sv ====
// Interrupt enable and priority register bank with request selection.
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps

// What this block does
// - Global gate bit 7 blocks every source.
// - With gate set, each source needs own enable.
// - UART enable covers transmit and receive flags.
// - Timer 1 enable passes timer 1 overflow.
// - External pin 1 enable passes pin 1.
// - Timer 0 enable passes timer 0 overflow.
// - External pin 0 enable passes pin 0.
// - Basic bits 6, 5 enable ADC, brown-out.
// - Extended bit 7 enables timer 2.
// - Extended bit 6 enables SPI.
// - Extended bit 5 enables brake interrupt.
// - Extended bit 4 watchdog; bit 3 reserved.
// - Extended bit 2 enables capture.
// - Extended bits 1, 0 keypad and I2C.
// - Basic source priority bits share its position.
// - Basic bit 7 priority belongs to capture.
// - Extended priority bits per source; 3:2 reserved.
// - All six registers reset to zero.
// - Both bits set level 3; high only level 2.
// - Only strictly higher level preempts service.
// - Equal levels resolved by fixed polling order.
module iep_ctrl (
  input  wire logic                      aclk,           // Core clock, 200 MHz.
  input  wire logic                      aresetn,        // Synchronous reset, active low.
  input  wire logic [iep_pkg::ADDR_W-1:0] awaddr,        // Write address.
  input  wire logic [2:0]                awprot,         // Write protection, unused.
  input  wire logic                      awvalid,        // Write address valid.
  output logic                           awready,        // Write address ready.
  input  wire logic [iep_pkg::DATA_W-1:0] wdata,         // Write data.
  input  wire logic [3:0]                wstrb,          // Write byte strobes.
  input  wire logic                      wvalid,         // Write data valid.
  output logic                           wready,         // Write data ready.
  output logic [1:0]                     bresp,          // Write answer.
  output logic                           bvalid,         // Write answer valid.
  input  wire logic                      bready,         // Write answer ready.
  input  wire logic [iep_pkg::ADDR_W-1:0] araddr,        // Read address.
  input  wire logic [2:0]                arprot,         // Read protection, unused.
  input  wire logic                      arvalid,        // Read address valid.
  output logic                           arready,        // Read address ready.
  output logic [iep_pkg::DATA_W-1:0]     rdata,          // Read data.
  output logic [1:0]                     rresp,          // Read answer.
  output logic                           rvalid,         // Read data valid.
  input  wire logic                      rready,         // Read data ready.
  input  iep_pkg::iep_src_t              src,            // Peripheral request flags.
  input  wire logic                      ext_irq_pin0_n, // External pin 0, active low, asynchronous.
  input  wire logic                      ext_irq_pin1_n, // External pin 1, active low, asynchronous.
  input  wire logic                      irq_take,       // Pulse: core vectors the offered request.
  input  wire logic                      irq_done,       // Pulse: core returns from a service routine.
  output iep_pkg::iep_out_t              irq_out         // Request offered to the core.
);
  import iep_pkg::*;

  // ************************************************************
  // Helper functions.
  // ************************************************************

  // Turns a high and low priority bit into a level.
  function automatic logic [1:0] prio_code(input logic hi, input logic lo);
    prio_code = {hi, lo};
  endfunction : prio_code

  // Index of the highest level held in the in-service mask.
  function automatic logic [1:0] top_level(input logic [3:0] act);
    logic [1:0] t;
    t = 2'h0;
    for (int i = 0; i < 4; i++) begin
      if (act[i]) begin
        t = i[1:0];
      end
    end
    top_level = t;
  endfunction : top_level

  // Picks the eligible source of highest level; ties go to the lowest rank.
  function automatic logic [3:0] pick(input logic [N_SRC-1:0] el, input logic [2*N_SRC-1:0] lv);
    logic [3:0] w;
    logic [1:0] b;
    logic       f;
    w = 4'h0;
    b = 2'h0;
    f = 1'b0;
    for (int i = 0; i < N_SRC; i++) begin
      if (el[i] && (!f || lv[2*i +: 2] > b)) begin
        w = i[3:0];
        b = lv[2*i +: 2];
        f = 1'b1;
      end
    end
    pick = w;
  endfunction : pick

  // Converts a byte address to a register index.
  function automatic logic [7:0] index_of(input logic [ADDR_W-1:0] a);
    index_of = a[ADDR_W-1:2];
  endfunction : index_of

  // ************************************************************
  // Registers and state.
  // ************************************************************
  logic [7:0]         en_b_q, ph_b_q, pl_b_q;   // Basic enable and priority registers.
  logic [7:0]         en_e_q, ph_e_q, pl_e_q;   // Extended enable and priority registers.
  logic [1:0]         pin0_s_q, pin1_s_q;       // Two-stage synchronisers for the pins.
  logic [3:0]         svc_q;                    // One bit per level currently in service.
  iep_out_t           out_q;                    // Registered request to the core.
  logic               aw_got_q, w_got_q;        // Address or data already taken.
  logic [ADDR_W-1:0]  aw_q;                     // Held write address.
  logic [DATA_W-1:0]  w_q;                      // Held write data.
  logic [3:0]         ws_q;                     // Held write strobes.
  logic               awr_q, wr_q, bv_q, arr_q, rv_q;  // Handshake flip-flops.
  logic [1:0]         br_q, rr_q;               // Answer codes.
  logic [DATA_W-1:0]  rd_q;                     // Read data.
  logic [N_SRC-1:0]   en_vec, req_vec, elig;    // Per-source enable, request and eligibility.
  logic [2*N_SRC-1:0] lvl;                      // Per-source priority level.
  logic [3:0]         win;                      // Selected source.
  logic [1:0]         svc_top;                  // Level of the innermost service.
  logic               win_ok;                   // Selected source may preempt.

  // ************************************************************
  // Source mapping.
  // ************************************************************

  // Builds the enable, request and level of every source in polling order.
  always_comb begin
    en_vec          = '0;
    en_vec[R_X0]    = en_b_q[B_X0];
    en_vec[R_BOD]   = en_b_q[B_BOD];
    en_vec[R_WDT]   = en_e_q[E_WDT];
    en_vec[R_T0]    = en_b_q[B_T0];
    en_vec[R_I2C]   = en_e_q[E_I2C];
    en_vec[R_ADC]   = en_b_q[B_ADC];
    en_vec[R_X1]    = en_b_q[B_X1];
    en_vec[R_KEY]   = en_e_q[E_KEY];
    en_vec[R_T1]    = en_b_q[B_T1];
    en_vec[R_UART]  = en_b_q[B_UART];
    en_vec[R_BRK]   = en_e_q[E_BRK];
    en_vec[R_SPI]   = en_e_q[E_SPI];
    en_vec[R_T2]    = en_e_q[E_T2];
    en_vec[R_CAPT]  = en_e_q[E_CAPT];
    req_vec         = '0;
    req_vec[R_X0]   = ~pin0_s_q[1];    // Low level on the pin requests.
    req_vec[R_BOD]  = src.brownout;
    req_vec[R_WDT]  = src.watchdog;
    req_vec[R_T0]   = src.timer0_overflow_flag;
    req_vec[R_I2C]  = src.i2c;
    req_vec[R_ADC]  = src.adc;
    req_vec[R_X1]   = ~pin1_s_q[1];
    req_vec[R_KEY]  = src.keypad;
    req_vec[R_T1]   = src.timer1_overflow_flag;
    req_vec[R_UART] = src.uart_tx_done_flag | src.uart_rx_done_flag;
    req_vec[R_BRK]  = src.brake;
    req_vec[R_SPI]  = src.spi;
    req_vec[R_T2]   = src.timer2;
    req_vec[R_CAPT] = src.capture;
    lvl                   = '0;
    lvl[2*R_X0 +: 2]      = prio_code(ph_b_q[B_X0], pl_b_q[B_X0]);
    lvl[2*R_BOD +: 2]     = prio_code(ph_b_q[B_BOD], pl_b_q[B_BOD]);
    lvl[2*R_WDT +: 2]     = prio_code(ph_e_q[E_WDT], pl_e_q[E_WDT]);
    lvl[2*R_T0 +: 2]      = prio_code(ph_b_q[B_T0], pl_b_q[B_T0]);
    lvl[2*R_I2C +: 2]     = prio_code(ph_e_q[E_I2C], pl_e_q[E_I2C]);
    lvl[2*R_ADC +: 2]     = prio_code(ph_b_q[B_ADC], pl_b_q[B_ADC]);
    lvl[2*R_X1 +: 2]      = prio_code(ph_b_q[B_X1], pl_b_q[B_X1]);
    lvl[2*R_KEY +: 2]     = prio_code(ph_e_q[E_KEY], pl_e_q[E_KEY]);
    lvl[2*R_T1 +: 2]      = prio_code(ph_b_q[B_T1], pl_b_q[B_T1]);
    lvl[2*R_UART +: 2]    = prio_code(ph_b_q[B_UART], pl_b_q[B_UART]);
    lvl[2*R_BRK +: 2]     = prio_code(ph_e_q[E_BRK], pl_e_q[E_BRK]);
    lvl[2*R_SPI +: 2]     = prio_code(ph_e_q[E_SPI], pl_e_q[E_SPI]);
    lvl[2*R_T2 +: 2]      = prio_code(ph_e_q[E_T2], pl_e_q[E_T2]);
    lvl[2*R_CAPT +: 2]    = prio_code(ph_b_q[B_CAPT], pl_b_q[B_CAPT]);
    elig    = req_vec & en_vec & {N_SRC{en_b_q[B_GLOBAL]}};
    win     = pick(elig, lvl);
    svc_top = top_level(svc_q);
    win_ok  = (|elig) && (svc_q == 4'h0 || lvl[2*win +: 2] > svc_top);
  end

  // ************************************************************
  // Pin synchronisers and request output.
  // ************************************************************

  // Brings the asynchronous pins onto the core clock; idle level is high.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin0_s_q <= 2'h3;
      pin1_s_q <= 2'h3;
    end else begin
      pin0_s_q <= {pin0_s_q[0], ext_irq_pin0_n};
      pin1_s_q <= {pin1_s_q[0], ext_irq_pin1_n};
    end
  end

  // Registers the chosen request so that the core sees glitch-free outputs.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_q <= '0;
    end else begin
      out_q.req   <= win_ok;
      out_q.id    <= win;
      out_q.level <= lvl[2*win +: 2];
    end
  end

  // Tracks the levels in service; a return closes the innermost one first.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      svc_q <= 4'h0;
    end else begin
      svc_q <= (irq_done ? (svc_q & ~(4'h1 << svc_top)) : svc_q)
             | (irq_take ? (4'h1 << out_q.level) : 4'h0);
    end
  end

  // ************************************************************
  // Register bus: write path.
  // ************************************************************
  logic              aw_take, w_take, commit;  // Handshakes and the write commit.
  logic [ADDR_W-1:0] wa;                       // Address of the committed write.
  logic [DATA_W-1:0] wd;                       // Data of the committed write.
  logic [3:0]        wsb;                      // Strobes of the committed write.
  logic              wmap;                     // Committed address is mapped.
  logic [7:0]        wi;                       // Committed register index.

  // Joins address and data, whichever arrives first.
  always_comb begin
    aw_take = awvalid & awr_q;
    w_take  = wvalid & wr_q;
    commit  = (aw_got_q | aw_take) & (w_got_q | w_take);
    wa      = aw_got_q ? aw_q : awaddr;
    wd      = w_got_q ? w_q : wdata;
    wsb     = w_got_q ? ws_q : wstrb;
    wi      = index_of(wa);
    wmap    = (wi == IDX_EN_BASIC) || (wi == IDX_PH_BASIC) || (wi == IDX_PL_BASIC)
           || (wi == IDX_EN_EXT) || (wi == IDX_PH_EXT) || (wi == IDX_PL_EXT);
  end

  // Holds the write channels and drives the write answer.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
      aw_q     <= '0;
      w_q      <= '0;
      ws_q     <= 4'h0;
      awr_q    <= 1'b0;
      wr_q     <= 1'b0;
      bv_q     <= 1'b0;
      br_q     <= RESP_OKAY;
    end else begin
      aw_got_q <= (aw_got_q | aw_take) & ~commit;
      w_got_q  <= (w_got_q | w_take) & ~commit;
      if (aw_take) begin
        aw_q <= awaddr;
      end
      if (w_take) begin
        w_q  <= wdata;
        ws_q <= wstrb;
      end
      awr_q <= ~((aw_got_q | aw_take) | commit | (bv_q & ~bready));
      wr_q  <= ~((w_got_q | w_take) | commit | (bv_q & ~bready));
      if (commit) begin
        bv_q <= 1'b1;
        br_q <= wmap ? RESP_OKAY : RESP_SLV;
      end else if (bready) begin
        bv_q <= 1'b0;
      end
    end
  end

  // Stores software writes; only byte lane 0 carries register data.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_b_q <= REG_RESET;
      ph_b_q <= REG_RESET;
      pl_b_q <= REG_RESET;
      en_e_q <= REG_RESET;
      ph_e_q <= REG_RESET;
      pl_e_q <= REG_RESET;
    end else if (commit && wsb[0]) begin
      if (wi == IDX_EN_BASIC) begin
        en_b_q <= wd[7:0];
      end
      if (wi == IDX_PH_BASIC) begin
        ph_b_q <= wd[7:0];
      end
      if (wi == IDX_PL_BASIC) begin
        pl_b_q <= wd[7:0];
      end
      if (wi == IDX_EN_EXT) begin
        en_e_q <= wd[7:0] & EN_EXT_MASK;
      end
      if (wi == IDX_PH_EXT) begin
        ph_e_q <= wd[7:0] & PR_EXT_MASK;
      end
      if (wi == IDX_PL_EXT) begin
        pl_e_q <= wd[7:0] & PR_EXT_MASK;
      end
    end
  end

  // ************************************************************
  // Register bus: read path.
  // ************************************************************
  logic       ar_take;  // Read address accepted.
  logic [7:0] ri;       // Read register index.

  // Answers a read one cycle after the address is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arr_q <= 1'b0;
      rv_q  <= 1'b0;
      rd_q  <= '0;
      rr_q  <= RESP_OKAY;
    end else begin
      arr_q <= ~(ar_take | (rv_q & ~rready));
      if (ar_take) begin
        rv_q <= 1'b1;
        rr_q <= RESP_OKAY;
        case (ri)
          IDX_EN_BASIC: rd_q <= {24'h0, en_b_q};
          IDX_PH_BASIC: rd_q <= {24'h0, ph_b_q};
          IDX_PL_BASIC: rd_q <= {24'h0, pl_b_q};
          IDX_EN_EXT:   rd_q <= {24'h0, en_e_q};
          IDX_PH_EXT:   rd_q <= {24'h0, ph_e_q};
          IDX_PL_EXT:   rd_q <= {24'h0, pl_e_q};
          IDX_STATUS:   rd_q <= {16'h0, out_q.req, 1'b0, out_q.level, out_q.id, svc_q, 4'h0};
          default: begin
            rd_q <= '0;
            rr_q <= RESP_SLV;
          end
        endcase
      end else if (rready) begin
        rv_q <= 1'b0;
      end
    end
  end

  // Read address decode.
  always_comb begin
    ar_take = arvalid & arr_q;
    ri      = index_of(araddr);
  end

  // Drives the ports straight from flip-flops.
  assign awready = awr_q;
  assign wready  = wr_q;
  assign bvalid  = bv_q;
  assign bresp   = br_q;
  assign arready = arr_q;
  assign rvalid  = rv_q;
  assign rdata   = rd_q;
  assign rresp   = rr_q;
  assign irq_out = out_q;

  // ************************************************************
  // Checks.
  // ************************************************************
  logic [N_SRC-1:0]   elig_h_q;  // Eligibility one cycle back.
  logic [2*N_SRC-1:0] lvl_h_q;   // Levels one cycle back.

  // Keeps the inputs of the last selection for the checks.
  always_ff @(posedge aclk) begin
    elig_h_q <= elig;
    lvl_h_q  <= lvl;
  end

  gate_blocks_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !en_b_q[B_GLOBAL] ##1 aresetn |-> !out_q.req) else $error("request while global gate off");
  enable_needed_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn) && out_q.req |-> elig_h_q[out_q.id]) else $error("request from ineligible source");
  uart_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !en_b_q[B_UART] ##1 aresetn |-> !(out_q.req && out_q.id == R_UART)) else $error("uart not gated");
  timer1_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !en_b_q[B_T1] ##1 aresetn |-> !(out_q.req && out_q.id == R_T1)) else $error("timer 1 not gated");
  reset_zero_a: assert property (@(posedge aclk)
    !aresetn |=> ({en_b_q, ph_b_q, pl_b_q, en_e_q, ph_e_q, pl_e_q} == 48'h0)) else $error("registers not cleared");
  level_code_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn) && out_q.req && out_q.id == R_T1 |-> out_q.level == $past({ph_b_q[B_T1], pl_b_q[B_T1]}))
    else $error("wrong level");
  capt_prio_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn) && out_q.req && out_q.id == R_CAPT |-> out_q.level == $past({ph_b_q[7], pl_b_q[7]}))
    else $error("capture priority not from basic bit 7");
  strict_preempt_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn) && out_q.req && $past(svc_q) != 4'h0 |-> out_q.level > $past(svc_top))
    else $error("preemption by equal or lower level");
  rank_order_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn) && out_q.req |-> out_q.id == pick(elig_h_q, lvl_h_q)) else $error("polling order broken");
  reserved_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    en_e_q[3] == 1'b0 && ph_e_q[3:2] == 2'h0 && pl_e_q[3:2] == 2'h0) else $error("reserved bit set");

endmodule : iep_ctrl

// ==== iep_core_model.sv ====
// Core model that vectors offered requests and returns from service.
`timescale 1ns/1ps
module iep_core_model (
  input  wire logic         aclk,     // Core clock.
  input  wire logic         aresetn,  // Synchronous reset, active low.
  input  iep_pkg::iep_out_t irq_out,  // Request offered to the core.
  input  wire logic         take_go,  // Bench asks the core to vector.
  input  wire logic         done_go,  // Bench asks the core to return.
  output logic              irq_take, // One-cycle take pulse.
  output logic              irq_done  // One-cycle return pulse.
);
  import iep_pkg::*;
  // Takes only while a request stands, and never twice in a row.
  always_ff @(posedge aclk) begin
    irq_take <= aresetn & take_go & irq_out.req & ~irq_take;
    irq_done <= aresetn & done_go & ~irq_done;
  end
endmodule : iep_core_model

// ==== interrupt_enable_priority_tb.sv ====
// Self-checking bench of the interrupt enable and priority bank.
`timescale 1ns/1ps
module interrupt_enable_priority_tb;
  import iep_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, arvalid, awready, wready, bvalid, arready, rvalid;
  logic pin0_n, pin1_n, take_go, done_go, irq_take, irq_done;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [DATA_W-1:0] wdata, rdata, d;
  logic [1:0]        bresp, rresp, r;
  iep_src_t          src;
  iep_out_t          irq_out;
  int                bad_count = 0;
  int                n_checks = 0;
  logic [7:0] idx [6] = '{IDX_EN_BASIC, IDX_PH_BASIC, IDX_PL_BASIC, IDX_EN_EXT, IDX_PH_EXT, IDX_PL_EXT};
  logic [7:0] msk [6] = '{8'hff, 8'hff, 8'hff, 8'hf7, 8'hf3, 8'hf3};
  // Rows: enable basic, enable ext, prio high, prio low, flags, pins, expected offer.
  logic [53:0] rows [18] = '{{32'h7ff70000,13'h1fff,2'h0,7'h00}, {32'h90000000,13'h0080,2'h3,7'h64},
    {32'h90000000,13'h0100,2'h3,7'h64}, {32'h88000808,13'h0040,2'h3,7'h63}, {32'h84000400,13'h0000,2'h1,7'h5a},
    {32'h82000002,13'h0004,2'h3,7'h4d}, {32'h81000000,13'h0000,2'h2,7'h40}, {32'hc0000000,13'h0010,2'h3,7'h54},
    {32'ha0000000,13'h0001,2'h3,7'h44}, {32'h80800000,13'h0800,2'h3,7'h70}, {32'h80400000,13'h0400,2'h3,7'h6c},
    {32'h80200000,13'h0200,2'h3,7'h68}, {32'h80100000,13'h0002,2'h3,7'h48}, {32'h80048080,13'h1000,2'h3,7'h77},
    {32'h80020000,13'h0020,2'h3,7'h5c}, {32'h80010000,13'h0008,2'h3,7'h50}, {32'h80000000,13'h1fff,2'h0,7'h00},
    {32'hfff71010,13'h1fff,2'h0,7'h4b}};
  iep_ctrl iep_ctrl_i (.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb(4'h1), .wvalid,
    .wready, .bresp, .bvalid, .bready(1'b1), .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready(1'b1), .src, .ext_irq_pin0_n(pin0_n), .ext_irq_pin1_n(pin1_n), .irq_take, .irq_done, .irq_out);
  iep_core_model iep_core_model_i (.aclk, .aresetn, .irq_out, .take_go, .done_go, .irq_take, .irq_done);
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  // Counts a comparison and reports a mismatch at once.
  task automatic chk(input string s, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  // One bus transfer; ready lines of the answers stay high throughout.
  task automatic bus(input logic w, input logic [7:0] x, v);
    int t = 0;
    @(posedge aclk);
    awaddr <= {x, 2'h0};
    araddr <= {x, 2'h0};
    wdata <= {24'h0, v};
    awvalid <= w;
    wvalid <= w;
    arvalid <= !w;
    do begin
      @(posedge aclk);
      d = rdata;
      r = w ? bresp : rresp;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (arready) arvalid <= 1'b0;
      t++;
    end while (!(w ? bvalid : rvalid) && t < 50);
    if (t >= 50 && !(w ? bvalid : rvalid)) chk("bus answer", 32'h1, 32'h0);
  endtask : bus
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim
  initial begin
    {aresetn, awvalid, wvalid, arvalid, take_go, done_go, awaddr, araddr, wdata, src} = '0;
    {pin0_n, pin1_n} = 2'h3;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (idx[k]) begin
      bus(1'b0, idx[k], 8'h00);
      chk("reset value", 32'h0, d);
      bus(1'b1, idx[k], 8'hff);
      bus(1'b0, idx[k], 8'h00);
      chk("writable bits", {24'h0, msk[k]}, d);
    end
    $display("register test done");
    foreach (rows[k]) begin
      src <= rows[k][21:9];
      {pin1_n, pin0_n} <= rows[k][8:7];
      foreach (idx[j]) bus(1'b1, idx[j], rows[k][53 - 8 * (j < 3 ? (j == 0 ? 0 : j + 1) : (j == 3 ? 1 : j - 2)) -: 8]);
      repeat (4) @(posedge aclk);
      chk("irq_out", {25'h0, rows[k][6:0]}, {25'h0, irq_out});
      $display("row %0d done", k);
    end
    bus(1'b1, IDX_EN_BASIC, 8'h98);
    bus(1'b1, IDX_PH_BASIC, 8'h08);
    bus(1'b1, IDX_PL_BASIC, 8'h08);
    src <= 13'h0040;
    repeat (4) @(posedge aclk);
    chk("offer before take", 32'h63, {25'h0, irq_out});
    take_go <= 1'b1;
    @(posedge aclk);
    take_go <= 1'b0;
    src <= 13'h00c0;
    repeat (4) @(posedge aclk);
    // With the request withheld, id and level still show the best candidate.
    chk("offer in service", {25'h0, 1'b0, R_T1, 2'h3}, {25'h0, irq_out});
    bus(1'b0, IDX_STATUS, 8'h00);
    chk("in service mask", 32'h8, {28'h0, d[7:4]});
    done_go <= 1'b1;
    @(posedge aclk);
    done_go <= 1'b0;
    repeat (4) @(posedge aclk);
    chk("offer after return", 32'h63, {25'h0, irq_out});
    $display("preemption test done");
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (idx[k]) begin
      bus(1'b0, idx[k], 8'h00);
      chk("value after reset", 32'h0, d);
    end
    chk("offer after reset", 32'h0, {25'h0, irq_out});
    $display("mid-run reset test done");
    bus(1'b0, 8'h01, 8'h00);
    chk("unmapped read", {30'h0, RESP_SLV}, {30'h0, r});
    bus(1'b1, 8'h01, 8'hff);
    chk("unmapped write", {30'h0, RESP_SLV}, {30'h0, r});
    $display("unmapped test done");
    end_sim();
  end
  // Ends a hung run well after the tests should have finished.
  initial begin
    #50us;
    bad_count++;
    end_sim();
  end
endmodule : interrupt_enable_priority_tb
